// ===== ssc_top.sv
// module: standby and system clock control registers with power mode sequencing
//
// Functional notes
// - standby control loads 08h, kept in software standby
// - halt enters sleep, subsleep or software standby
// - standby-on-halt changes only by write, reset or hardware standby
// - leaving software standby waits the settling time
// - settling code maps to listed cycle counts
// - standby control low three bits read zero
// - bus floats in software standby unless hold set
// - clock control loads 00h, kept in software standby
// - bit 7 disables clock output, default enabled
// - divider field selects full clock to /32
// - bits 6,3 writable; bits 5,4 read zero
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`default_nettype none
`timescale 1ns/100ps

module ssc_top
  import ssc_pkg::*;
#(
  parameter int unsigned SETTLE_CYC [8] = '{SETTLE_CYC_0, SETTLE_CYC_1, SETTLE_CYC_2,
                                            SETTLE_CYC_3, SETTLE_CYC_4, SETTLE_CYC_5,
                                            SETTLE_CYC_6, SETTLE_CYC_7}
)
(
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  // axi4-lite write address and data
  input  wire logic [ssc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // axi4-lite read
  input  wire logic [ssc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // power mode events
  input  wire logic                   hw_standby,
  input  wire logic                   halt_exec,
  input  wire logic                   subactive,
  input  wire logic                   wake_req,
  output ssc_pkg::ssc_mode_t          power_mode,
  output logic                        resume_done,
  output logic                        bus_master_clk_en,
  // external bus pins
  input  wire ssc_pkg::ssc_extbus_t   ext_bus_int,
  output ssc_pkg::ssc_extbus_t        ext_bus_o,
  output logic                        ext_bus_oe,
  // clock output pin
  output logic                        clkout_o,
  output logic                        clkout_oe
);

  // ==========================================================================
  // declarations
  // ==========================================================================
  logic              aw_got_r;
  logic              w_got_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [7:0]        w_data_r;
  logic              w_lane0_r;
  logic              awready_r;
  logic              wready_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [1:0]        rresp_r;
  logic [31:0]       rdata_r;
  logic [7:0]        stby_ctrl_r;
  logic [7:0]        stby_ctrl_nxt;
  logic [7:0]        sys_clk_ctrl_r;
  logic [7:0]        sys_clk_ctrl_nxt;
  ssc_mode_t         mode_r;
  ssc_mode_t         mode_nxt;
  logic              resume_r;
  logic              bmclk_en_r;
  ssc_extbus_t       ext_bus_r;
  ssc_extbus_t       ext_bus_nxt;
  logic              ext_bus_oe_r;
  logic              clkout_r;
  logic              clkout_nxt;
  logic              clkout_oe_r;

  // ==========================================================================
  // register decode, shared by the write and read paths
  // ==========================================================================
  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
    logic [1:0] s;
    s = 2'h3;
    if (a == OFS_STBY_CTRL)
      s = 2'h0;
    else if (a == OFS_SYS_CLK_CTRL)
      s = 2'h1;
    else if (a == OFS_STATUS)
      s = 2'h2;
    return s;
  endfunction

  // ==========================================================================
  // write channel: address and data taken in either order
  // ==========================================================================
  logic       aw_fire;
  logic       w_fire;
  logic       aw_have;
  logic       w_have;
  logic       wr_do;
  logic [1:0] wr_sel;
  logic       wr_stby;
  logic       wr_sck;

  assign aw_fire = s_axi_awvalid & awready_r;
  assign w_fire  = s_axi_wvalid & wready_r;
  assign wr_do   = aw_got_r & w_got_r & ~bvalid_r;
  assign aw_have = (aw_got_r | aw_fire) & ~wr_do;
  assign w_have  = (w_got_r | w_fire) & ~wr_do;
  assign wr_sel  = reg_sel(aw_addr_r);
  // only byte lane 0 carries the 8-bit registers
  assign wr_stby = wr_do & w_lane0_r & (wr_sel == 2'h0);
  assign wr_sck  = wr_do & w_lane0_r & (wr_sel == 2'h1);

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= 8'h00;
      w_lane0_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end
    else
    begin
      aw_got_r  <= aw_have;
      w_got_r   <= w_have;
      awready_r <= ~aw_have;
      wready_r  <= ~w_have;
      if (aw_fire)
        aw_addr_r <= s_axi_awaddr;
      if (w_fire)
      begin
        w_data_r  <= s_axi_wdata[7:0];
        w_lane0_r <= s_axi_wstrb[0];
      end
      if (wr_do)
      begin
        bvalid_r <= 1'b1;
        bresp_r  <= (wr_sel[1]) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  // ==========================================================================
  // control registers: reset and hardware standby load defaults
  // ==========================================================================
  assign stby_ctrl_nxt    = hw_standby ? STBY_CTRL_RST :
                            wr_stby ? (w_data_r & STBY_CTRL_WMASK) :
                            stby_ctrl_r;
  assign sys_clk_ctrl_nxt = hw_standby ? SYS_CLK_CTRL_RST :
                            wr_sck ? (w_data_r & SYS_CLK_CTRL_WMASK) :
                            sys_clk_ctrl_r;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stby_ctrl_r    <= STBY_CTRL_RST;
      sys_clk_ctrl_r <= SYS_CLK_CTRL_RST;
    end
    else
    begin
      stby_ctrl_r    <= stby_ctrl_nxt;
      sys_clk_ctrl_r <= sys_clk_ctrl_nxt;
    end
  end

  wire       standby_on_halt     = stby_ctrl_r[STBY_ON_HALT_BIT];
  wire [2:0] settle_time_select  = stby_ctrl_r[SETTLE_SEL_LSB +: 3];
  wire       bus_hold_in_standby = stby_ctrl_r[BUS_HOLD_BIT];
  wire       clkout_disable      = sys_clk_ctrl_r[CLKOUT_DIS_BIT];
  wire [2:0] bus_master_clk_div  = sys_clk_ctrl_r[BMCLK_DIV_LSB +: 3];

  // ==========================================================================
  // read channel
  // ==========================================================================
  logic        ar_fire;
  logic        rvalid_nxt;
  logic [1:0]  rd_sel;
  logic [31:0] rd_word;

  assign ar_fire    = s_axi_arvalid & arready_r;
  assign rvalid_nxt = ar_fire | (rvalid_r & ~s_axi_rready);
  assign rd_sel     = reg_sel(s_axi_araddr);
  assign rd_word    = (rd_sel == 2'h0) ? {24'h000000, stby_ctrl_r} :
                      (rd_sel == 2'h1) ? {24'h000000, sys_clk_ctrl_r} :
                      (rd_sel == 2'h2) ? {24'h000000, 5'h00, mode_r} :
                      32'h00000000;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= 32'h00000000;
    end
    else
    begin
      arready_r <= ~rvalid_nxt;
      rvalid_r  <= rvalid_nxt;
      if (ar_fire)
      begin
        rdata_r <= rd_word;
        rresp_r <= (rd_sel == 2'h3) ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  // ==========================================================================
  // power mode sequencing
  // ==========================================================================
  logic settle_done;

  ssc_settle_timer #(
    .SETTLE_CYC (SETTLE_CYC)
  ) u_settle (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .start    (mode_r == PM_SW_STBY && wake_req && !hw_standby),
    .abort    (hw_standby),
    .sel      (settle_time_select),
    .done     (settle_done)
  );

  always_comb
  begin
    mode_nxt = mode_r;
    if (hw_standby)
      mode_nxt = PM_HW_STBY;
    else
    begin
      unique case (mode_r)
        PM_RUN:
          if (halt_exec)
            mode_nxt = standby_on_halt ? PM_SW_STBY :
                       (subactive ? PM_SUBSLEEP : PM_SLEEP);
        PM_SLEEP, PM_SUBSLEEP:
          if (wake_req)
            mode_nxt = PM_RUN;
        PM_SW_STBY:
          if (wake_req)
            mode_nxt = PM_SETTLE;
        PM_SETTLE:
          if (settle_done)
            mode_nxt = PM_RUN;
        PM_HW_STBY:
          mode_nxt = PM_RUN;
        default:
          mode_nxt = PM_RUN;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_r   <= PM_RUN;
      resume_r <= 1'b0;
    end
    else
    begin
      mode_r   <= mode_nxt;
      resume_r <= (mode_r == PM_SETTLE) && (mode_nxt == PM_RUN);
    end
  end

  // ==========================================================================
  // bus master clock and pins
  // ==========================================================================
  logic div_tick;
  logic in_stby;

  ssc_clk_div u_div (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .div_sel  (bus_master_clk_div),
    .tick     (div_tick)
  );

  assign in_stby     = (mode_r == PM_SW_STBY) || (mode_r == PM_SETTLE);
  // holding the bus freezes the last driven value rather than the live one
  assign ext_bus_nxt = (mode_nxt == PM_HW_STBY) ? EXTBUS_RST :
                       in_stby ? ext_bus_r : ext_bus_int;
  // the pin can only toggle at half rate since it must come from a flop
  assign clkout_nxt  = (mode_nxt == PM_RUN || mode_nxt == PM_SLEEP ||
                        mode_nxt == PM_SUBSLEEP) && !clkout_disable ?
                       ~clkout_r : 1'b1;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bmclk_en_r   <= 1'b0;
      ext_bus_r    <= EXTBUS_RST;
      ext_bus_oe_r <= 1'b0;
      clkout_r     <= 1'b1;
      clkout_oe_r  <= 1'b0;
    end
    else
    begin
      bmclk_en_r   <= div_tick && (mode_nxt == PM_RUN);
      ext_bus_r    <= ext_bus_nxt;
      ext_bus_oe_r <= (mode_nxt != PM_HW_STBY) &&
                      !((mode_nxt == PM_SW_STBY || mode_nxt == PM_SETTLE) &&
                        !bus_hold_in_standby);
      clkout_r     <= clkout_nxt;
      clkout_oe_r  <= (mode_nxt != PM_HW_STBY);
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign s_axi_awready     = awready_r;
  assign s_axi_wready      = wready_r;
  assign s_axi_bvalid      = bvalid_r;
  assign s_axi_bresp       = bresp_r;
  assign s_axi_arready     = arready_r;
  assign s_axi_rvalid      = rvalid_r;
  assign s_axi_rresp       = rresp_r;
  assign s_axi_rdata       = rdata_r;
  assign power_mode        = mode_r;
  assign resume_done       = resume_r;
  assign bus_master_clk_en = bmclk_en_r;
  assign ext_bus_o         = ext_bus_r;
  assign ext_bus_oe        = ext_bus_oe_r;
  assign clkout_o          = clkout_r;
  assign clkout_oe         = clkout_oe_r;

  // ==========================================================================
  // checks
  // ==========================================================================
  logic [SETTLE_W-1:0] chk_len_r;
  logic [SETTLE_W-1:0] chk_exp_r;

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      chk_len_r <= '0;
      chk_exp_r <= '0;
    end
    else
    begin
      chk_len_r <= (mode_r == PM_SETTLE) ? chk_len_r + 1'b1 : '0;
      if (mode_r == PM_SW_STBY)
        chk_exp_r <= SETTLE_W'(SETTLE_CYC[settle_time_select]);
    end
  end

  a_stby_reset_val: assert property (@(posedge core_clk) disable iff (sys_rst)
    hw_standby |=> stby_ctrl_r == STBY_CTRL_RST && mode_r == PM_HW_STBY)
    else $error("standby control not reloaded by hardware standby");

  a_halt_to_standby: assert property (@(posedge core_clk) disable iff (sys_rst)
    mode_r == PM_RUN && halt_exec && standby_on_halt && !hw_standby
    |=> mode_r == PM_SW_STBY ##1 (mode_r == PM_SW_STBY || $past(wake_req) || $past(hw_standby)))
    else $error("halt did not enter software standby");

  a_halt_to_sleep: assert property (@(posedge core_clk) disable iff (sys_rst)
    mode_r == PM_RUN && halt_exec && !standby_on_halt && !hw_standby
    |=> mode_r == ($past(subactive) ? PM_SUBSLEEP : PM_SLEEP))
    else $error("halt did not enter sleep or subsleep");

  a_halt_bit_kept: assert property (@(posedge core_clk) disable iff (sys_rst)
    !wr_stby && !hw_standby |=> $stable(standby_on_halt))
    else $error("standby-on-halt changed without a write");

  a_settle_length: assert property (@(posedge core_clk) disable iff (sys_rst)
    mode_r == PM_SETTLE && mode_nxt == PM_RUN |-> chk_len_r + 1'b1 == chk_exp_r)
    else $error("settling wait has the wrong length");

  a_reserved_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    ar_fire && rd_sel == 2'h0 |=> rdata_r[2:0] == 3'h0)
    else $error("standby control low bits read back nonzero");

  a_fixed_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    ar_fire && rd_sel == 2'h1 |=> rdata_r[5:4] == 2'h0)
    else $error("clock control fixed bits read back nonzero");

  a_bus_float: assert property (@(posedge core_clk) disable iff (sys_rst)
    mode_nxt == PM_SW_STBY && !bus_hold_in_standby |=> !ext_bus_oe ##1 1'b1)
    else $error("bus driven in standby with hold clear");

  a_bus_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    mode_r == PM_SW_STBY && $past(mode_r) == PM_SW_STBY && bus_hold_in_standby
    |-> ext_bus_oe && $stable(ext_bus_o))
    else $error("bus not held in standby with hold set");

  a_sck_reset_val: assert property (@(posedge core_clk) disable iff (sys_rst)
    hw_standby |=> sys_clk_ctrl_r == SYS_CLK_CTRL_RST && !clkout_oe)
    else $error("clock control not reloaded by hardware standby");

  // the pin follows the mode on the same edge but the disable bit one edge late, so a fresh disable bit is judged a cycle on
  a_clkout_high: assert property (@(posedge core_clk) disable iff (sys_rst)
    in_stby || (clkout_disable && $past(clkout_disable)) |-> clkout_o)
    else $error("clock pin not held high");

endmodule

`default_nettype wire

// ===== ssc_pkg.sv
// package: register map, field layout, reset values and types of the standby clock control block
`default_nettype none

package ssc_pkg;

  // ==========================================================================
  // register map (byte offsets on the register bus)
  // ==========================================================================
  localparam int unsigned ADDR_W          = 4;
  localparam logic [3:0]  OFS_STBY_CTRL   = 4'h0;
  localparam logic [3:0]  OFS_SYS_CLK_CTRL = 4'h4;
  localparam logic [3:0]  OFS_STATUS      = 4'h8;

  // ==========================================================================
  // reset values and writable bits
  // ==========================================================================
  localparam logic [7:0]  STBY_CTRL_RST      = 8'h08;
  localparam logic [7:0]  SYS_CLK_CTRL_RST   = 8'h00;
  localparam logic [7:0]  STBY_CTRL_WMASK    = 8'hF8;
  localparam logic [7:0]  SYS_CLK_CTRL_WMASK = 8'hCF;

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int unsigned STBY_ON_HALT_BIT   = 7;
  localparam int unsigned SETTLE_SEL_LSB     = 4;
  localparam int unsigned BUS_HOLD_BIT       = 3;
  localparam int unsigned CLKOUT_DIS_BIT     = 7;
  localparam int unsigned BMCLK_DIV_LSB      = 0;

  // ==========================================================================
  // settling waits in system clock cycles, indexed by the select code
  // ==========================================================================
  localparam int unsigned SETTLE_W     = 19;
  localparam int unsigned SETTLE_CYC_0 = 8192;
  localparam int unsigned SETTLE_CYC_1 = 16384;
  localparam int unsigned SETTLE_CYC_2 = 32768;
  localparam int unsigned SETTLE_CYC_3 = 65536;
  localparam int unsigned SETTLE_CYC_4 = 131072;
  localparam int unsigned SETTLE_CYC_5 = 262144;
  localparam int unsigned SETTLE_CYC_6 = 2048;
  localparam int unsigned SETTLE_CYC_7 = 16;

  // ==========================================================================
  // bus answers and types
  // ==========================================================================
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int unsigned DIV_CNT_W   = 5;

  typedef enum logic [2:0] {
    PM_RUN,
    PM_SLEEP,
    PM_SUBSLEEP,
    PM_SW_STBY,
    PM_SETTLE,
    PM_HW_STBY
  } ssc_mode_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  chip_selects_n;
    logic        address_strobe_n;
    logic        read_strobe_n;
    logic        upper_write_strobe_n;
    logic        lower_write_strobe_n;
  } ssc_extbus_t;

  localparam ssc_extbus_t EXTBUS_RST = '{24'h000000, 8'hFF, 1'b1, 1'b1, 1'b1, 1'b1};

endpackage

`default_nettype wire

// ===== ssc_settle_timer.sv
// module: oscillator settling wait counter for leaving software standby
`default_nettype none
`timescale 1ns/100ps

module ssc_settle_timer
  import ssc_pkg::*;
#(
  parameter int unsigned SETTLE_CYC [8] = '{SETTLE_CYC_0, SETTLE_CYC_1, SETTLE_CYC_2,
                                            SETTLE_CYC_3, SETTLE_CYC_4, SETTLE_CYC_5,
                                            SETTLE_CYC_6, SETTLE_CYC_7}
)
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // control
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic [2:0] sel,
  // status
  output logic            done
);

  logic [SETTLE_W-1:0] cnt_r;
  logic [SETTLE_W-1:0] cnt_nxt;

  // ==========================================================================
  // count down the loaded wait; done marks the last waiting cycle
  // ==========================================================================
  assign cnt_nxt = abort ? '0 :
                   start ? SETTLE_W'(SETTLE_CYC[sel]) :
                   (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r;
  assign done    = (cnt_r == SETTLE_W'(1));

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

endmodule

`default_nettype wire

// ===== ssc_clk_div.sv
// module: medium-speed prescaler giving the bus master clock enable
`default_nettype none
`timescale 1ns/100ps

module ssc_clk_div
  import ssc_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  // selection
  input  wire logic [2:0] div_sel,
  // one-cycle enable at the selected rate
  output logic            tick
);

  logic [DIV_CNT_W-1:0] cnt_r;

  // codes 11x are undefined; they fall back to the full clock
  function automatic logic div_match(input logic [DIV_CNT_W-1:0] c, input logic [2:0] s);
    logic m;
    m = 1'b1;
    case (s)
      3'h1: m = &c[0:0];
      3'h2: m = &c[1:0];
      3'h3: m = &c[2:0];
      3'h4: m = &c[3:0];
      3'h5: m = &c[4:0];
      default: m = 1'b1;
    endcase
    return m;
  endfunction

  assign tick = div_match(cnt_r, div_sel);

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + 1'b1;
  end

endmodule

`default_nettype wire

// ===== ssc_top_tb.sv
// testbench: register bus, power mode and pin checks of the standby clock control block
`timescale 1ns/100ps
`default_nettype none
module ssc_top_tb;
  import ssc_pkg::*;
  // ==========================================================================
  // signals
  // ==========================================================================
  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        hw_standby, halt_exec, subactive, wake_req, resume_done, bus_master_clk_en;
  logic        ext_bus_oe, clkout_o, clkout_oe;
  ssc_mode_t   power_mode;
  ssc_extbus_t ext_bus_int, ext_bus_o, eb;
  int          error_cnt = 0, compares = 0, seed = 32'h9873, n, g, k;
  logic [33:0] bq[$], rq[$];
  logic [7:0]  v;

  // short settling table keeps the run small; expectations use these figures
  ssc_top #(.SETTLE_CYC('{64, 80, 96, 112, 128, 144, 48, 16})) u_ssc_top (
    .core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .hw_standby(hw_standby), .halt_exec(halt_exec),
    .subactive(subactive), .wake_req(wake_req), .power_mode(power_mode),
    .resume_done(resume_done), .bus_master_clk_en(bus_master_clk_en),
    .ext_bus_int(ext_bus_int), .ext_bus_o(ext_bus_o), .ext_bus_oe(ext_bus_oe),
    .clkout_o(clkout_o), .clkout_oe(clkout_oe));

  always #20 core_clk = ~core_clk;

  // live bus values change every cycle so that a frozen bus can be told apart
  always @(posedge core_clk) ext_bus_int <= {4'hA, 32'($random(seed))};

  // ==========================================================================
  // compare, report and bus tasks
  // ==========================================================================
  task cmp(input logic [33:0] exp, input logic [33:0] act);
    compares++;
    if (act !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t exp=%h act=%h", $time, exp, act);
    end
  endtask

  task results;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // a wait that uses up its bound is a mismatch and ends the run
  task bound(input int c, input int lim);
    if (c >= lim)
    begin
      error_cnt++;
      results;
    end
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    int t;
    bq.push_back({r, 32'h0});
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    t = 0;
    do
    begin
      @(posedge core_clk);
      t++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && t < 50);
    s_axi_bready <= 1'b0;
    bound(t, 50);
  endtask

  task rd(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
    int t;
    rq.push_back({r, 24'h0, d});
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    t = 0;
    do
    begin
      @(posedge core_clk);
      t++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready) && t < 50);
    s_axi_rready <= 1'b0;
    bound(t, 50);
  endtask

  // one-cycle event, then the new mode is looked at in the first cycle it stands
  task pulse(input bit w, input ssc_mode_t m);
    @(posedge core_clk);
    if (w) wake_req <= 1'b1; else halt_exec <= 1'b1;
    @(posedge core_clk);
    wake_req  <= 1'b0;
    halt_exec <= 1'b0;
    @(negedge core_clk);
    cmp({31'h0, m}, {31'h0, power_mode});
  endtask

  // bus answers are matched against the oldest note in order of issue
  always @(posedge core_clk)
  begin
    if (s_axi_bvalid && s_axi_bready) cmp(bq.pop_front(), {s_axi_bresp, 32'h0});
    if (s_axi_rvalid && s_axi_rready) cmp(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
  end

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, hw_standby, halt_exec, subactive} = '0;
    wake_req    = 1'b0;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(OFS_STBY_CTRL, 8'h08, RESP_OKAY);
    rd(OFS_SYS_CLK_CTRL, 8'h00, RESP_OKAY);
    wr(OFS_STBY_CTRL, 8'hFF, RESP_OKAY);
    rd(OFS_STBY_CTRL, 8'hF8, RESP_OKAY);
    for (k = 0; k < 4; k++)
    begin
      v = 8'($random(seed));
      wr(OFS_SYS_CLK_CTRL, v, RESP_OKAY);
      rd(OFS_SYS_CLK_CTRL, v & 8'hCF, RESP_OKAY);
    end
    wr(4'hC, 8'h5A, RESP_SLVERR);
    rd(4'hC, 8'h00, RESP_SLVERR);
    rd(OFS_STATUS, 8'(PM_RUN), RESP_OKAY);
    // gap between two enables, measured after the new divider has settled in
    for (k = 0; k < 6; k++)
    begin
      wr(OFS_SYS_CLK_CTRL, 8'(k), RESP_OKAY);
      repeat (2)
      begin
        n = 0;
        while (!bus_master_clk_en && n < 100) begin @(negedge core_clk); n++; end
        bound(n, 100);
        @(negedge core_clk);
        g = 1;
        while (!bus_master_clk_en && g < 100) begin @(negedge core_clk); g++; end
        bound(g, 100);
      end
      cmp(34'(1 << k), 34'(g));
    end
    wr(OFS_SYS_CLK_CTRL, 8'h80, RESP_OKAY);
    repeat (2) @(negedge core_clk);
    cmp(34'h1, {33'h0, clkout_o});
    wr(OFS_SYS_CLK_CTRL, 8'h00, RESP_OKAY);
    @(negedge core_clk);
    v[0] = clkout_o;
    @(negedge core_clk);
    cmp({33'h0, ~v[0]}, {33'h0, clkout_o});
    // software standby with both hold settings and two settling codes
    for (k = 0; k < 2; k++)
    begin
      // the bench stands for an external clock on a non-flash part: every code is legal
      v = {1'b1, 3'(7 - k), k[0], 3'b000};
      wr(OFS_STBY_CTRL, v, RESP_OKAY);
      pulse(1'b0, PM_SW_STBY);
      cmp({33'h0, k[0]}, {33'h0, ext_bus_oe});
      cmp(34'h1, {33'h0, clkout_o});
      eb = ext_bus_o;
      pulse(1'b1, PM_SETTLE);
      cmp(34'(eb), 34'(ext_bus_o));
      n = 0;
      while (power_mode === PM_SETTLE && n < 400) begin n++; @(negedge core_clk); end
      bound(n, 400);
      cmp(34'(k ? 48 : 16), 34'(n));
      // resume_done rises with the return to run and stands one cycle
      cmp(34'h1, {33'h0, resume_done});
      @(negedge core_clk);
      cmp(34'h0, {33'h0, resume_done});
      rd(OFS_STBY_CTRL, v, RESP_OKAY);
    end
    wr(OFS_STBY_CTRL, 8'h08, RESP_OKAY);
    for (k = 0; k < 2; k++)
    begin
      @(posedge core_clk);
      subactive <= k[0];
      pulse(1'b0, k ? PM_SUBSLEEP : PM_SLEEP);
      pulse(1'b1, PM_RUN);
    end
    wr(OFS_STBY_CTRL, 8'hF0, RESP_OKAY);
    wr(OFS_SYS_CLK_CTRL, 8'h85, RESP_OKAY);
    @(posedge core_clk);
    hw_standby <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    cmp({31'h0, PM_HW_STBY}, {31'h0, power_mode});
    cmp(34'h0, {32'h0, ext_bus_oe, clkout_oe});
    @(posedge core_clk);
    hw_standby <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd(OFS_STBY_CTRL, 8'h08, RESP_OKAY);
    rd(OFS_SYS_CLK_CTRL, 8'h00, RESP_OKAY);
    @(posedge core_clk);
    results;
  end
endmodule
`default_nettype wire
